// ==== hw/pom_fcs.sv ====
`timescale 1ns/1ps
`default_nettype none
module pom_fcs (
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  pom_fcs_if.gen    fcs_io
);
  logic [31:0] crc;
  logic [31:0] next_crc;

  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  d);
    logic [31:0] r;
    r = c ^ {24'h0, d};
    for (int k = 0; k < 8; k++)
      r = r[0] ? ((r >> 1) ^ pom_pkg::CRC_POLY) : (r >> 1);
    return r;
  endfunction

  always_comb
  begin
    next_crc = crc;
    if (fcs_io.upd)
      next_crc = crc_byte(fcs_io.start ? pom_pkg::CRC_INIT : crc,
                          fcs_io.data);
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      crc <= pom_pkg::CRC_INIT;
    else
      crc <= next_crc;
  end

  assign fcs_io.fcs = ~crc;
endmodule
`default_nettype wire

// ==== hw/pom_fcs_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface pom_fcs_if;
  logic        start;
  logic        upd;
  logic [7:0]  data;
  logic [31:0] fcs;
  modport gen (input start, input upd, input data, output fcs);
  modport usr (output start, output upd, output data, input fcs);
endinterface
`default_nettype wire

// ==== hw/pom_pkg.sv ====
package pom_pkg;
  localparam int         LINE_DEPTH = 8;
  localparam int         FCS_SPAN   = 4;
  localparam logic [7:0] IDX_FIRST  = 8'h00;
  localparam logic [7:0] IDX_MAX    = 8'hff;
  localparam logic [7:0] CF_FIRST   = 8'h08;
  localparam logic [7:0] CF_LAST    = 8'h0d;
  localparam logic [7:0] NS_BYTES   = 8'h04;
  localparam logic [7:0] BYTE_ONE   = 8'h01;
  localparam logic [3:0] TYPE_SYNC  = 4'h0;
  localparam logic [3:0] TYPE_DREQ  = 4'h1;
  localparam logic [1:0] SEC_NONE   = 2'h0;
  localparam logic [1:0] SEC_1B     = 2'h1;
  localparam logic [1:0] SEC_4B     = 2'h2;
  localparam logic [1:0] CORR_A     = 2'h1;
  localparam logic [1:0] CORR_B     = 2'h2;
  localparam logic [1:0] CORR_C     = 2'h3;
  localparam logic [1:0] FCS_FIRST  = 2'h0;
  localparam logic [31:0] CRC_INIT  = 32'hffffffff;
  localparam logic [31:0] CRC_POLY  = 32'hedb88320;

  typedef struct packed {
    logic       valid;
    logic       sop;
    logic       eop;
    logic       hdr;
    logic       fcs;
    logic [7:0] idx;
    logic [7:0] data;
  } pom_ent_s;

  function automatic logic [7:0] pom_sec_len(input logic [1:0] s);
    if (s == SEC_NONE)
      return 8'h00;
    else if (s == SEC_1B)
      return 8'h01;
    else if (s == SEC_4B)
      return 8'h04;
    return 8'h06;
  endfunction

  function automatic logic [47:0] pom_pick(input logic [1:0]  s,
                                           input logic [31:0] a,
                                           input logic [31:0] b,
                                           input logic [31:0] c);
    logic [31:0] v;
    v = 32'h0;
    if (s == CORR_A)
      v = a;
    else if (s == CORR_B)
      v = b;
    else if (s == CORR_C)
      v = c;
    return {{16{v[31]}}, v};
  endfunction
endpackage

// ==== hw/pom_top.sv ====
// Summary of operation
// - Egress clear zeroes the seconds and nanoseconds bytes.
// - Ingress messages get 1, 4 or 6 seconds bytes unless disabled.
// - Seconds offset counts from header start, unused when disabled.
// - Nanoseconds insertion writes all four nanoseconds bytes.
// - Nanoseconds offset counts from header start, unused when off.
// - Only types with their insertion enable set get time inserted.
// - Ingress insertion has one enable per message type 0 to 7.
// - Three correction values, added on ingress, subtracted on egress.
// - Per type and direction a field picks the correction value.
// - Correction value A doubles as the asymmetry correction.
// - Mean path delay is added to ingress Sync correctionField.
// - Circuit emulation mode leaves correctionField untouched; stamps still go in.
// - A pps edge captures the time, nanoseconds give phase error.
// - Residence correction for Sync and Delay_Req when enabled.
// - Egress insertion has its own per-type enables.
`timescale 1ns/1ps
`default_nettype none
module pom_top (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        in_valid_in,
  input  wire logic [7:0]  in_data_in,
  input  wire logic        in_sop_in,
  input  wire logic        in_eop_in,
  input  wire logic        ptp_start_in,
  input  wire logic        ingress_in,
  input  wire logic [47:0] time_sec_in,
  input  wire logic [31:0] time_ns_in,
  input  wire logic        pps_in,
  input  wire logic        egress_ts_clear_en_in,
  input  wire logic [1:0]  seconds_insert_size_in,
  input  wire logic [7:0]  seconds_insert_offset_in,
  input  wire logic        nanos_insert_en_in,
  input  wire logic [7:0]  nanos_insert_offset_in,
  input  wire logic [7:0]  rx_ts_write_enables_in,
  input  wire logic [7:0]  tx_ts_write_enables_in,
  input  wire logic [31:0] correction_value_a_in,
  input  wire logic [31:0] correction_value_b_in,
  input  wire logic [31:0] correction_value_c_in,
  input  wire logic [15:0] rx_correction_select_in,
  input  wire logic [15:0] tx_correction_select_in,
  input  wire logic [31:0] mean_path_delay_in,
  input  wire logic        mean_path_delay_en_in,
  input  wire logic        residence_corr_en_in,
  input  wire logic        cem_mode_in,
  output logic             out_valid_out,
  output logic [7:0]       out_data_out,
  output logic             out_sop_out,
  output logic             out_eop_out,
  output logic             event_stamp_valid_out,
  output logic [47:0]      event_stamp_sec_out,
  output logic [31:0]      event_stamp_ns_out
);
  localparam int D = pom_pkg::LINE_DEPTH;

  pom_pkg::pom_ent_s line [D];
  pom_pkg::pom_ent_s next_line [D];
  pom_pkg::pom_ent_s ent_in;
  pom_pkg::pom_ent_s e;
  logic        drain, next_drain, in_hdr, next_in_hdr, adv;
  logic [7:0]  idx_cnt, next_idx_cnt;
  logic        fr_rx, next_fr_rx;
  logic [3:0]  fr_type, next_fr_type;
  logic [47:0] fr_sec, next_fr_sec, cf_raw, next_cf_raw;
  logic [47:0] cf_new, next_cf_new, adj, corr48, cf_sh, sec_sh;
  logic [31:0] fr_ns, next_fr_ns, ns_sh, fcs_sh;
  logic [1:0]  sel2, fcs_cnt, next_fcs_cnt;
  logic [7:0]  sec_n, sec_rel, ns_rel, od;
  logic        ins_ok, clr_ok, sec_hit, ns_hit, cf_hit;
  logic        next_out_valid, next_out_sop, next_out_eop;
  logic [7:0]  next_out_data;
  logic        pps_s1, pps_s2, pps_s3;
  pom_fcs_if   fcs_io ();

  pom_fcs u_fcs (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .fcs_io   (fcs_io)
  );

  // Input side, delay line and frame context
  always_comb
  begin
    ent_in       = '0;
    ent_in.valid = in_valid_in;
    ent_in.sop   = in_sop_in;
    ent_in.eop   = in_eop_in;
    ent_in.data  = in_data_in;
    ent_in.hdr   = in_valid_in & (ptp_start_in | in_hdr);
    ent_in.idx   = ptp_start_in ? pom_pkg::IDX_FIRST : idx_cnt;
    ent_in.fcs   = in_valid_in & in_eop_in;
    // Gaps inside a frame hold the line so byte spacing stays fixed
    adv          = in_valid_in | drain;
    next_line    = line;
    next_drain   = drain;
    next_in_hdr  = in_hdr;
    next_idx_cnt = idx_cnt;
    next_fr_rx   = fr_rx;
    next_fr_sec  = fr_sec;
    next_fr_ns   = fr_ns;
    next_fr_type = fr_type;
    next_cf_raw  = cf_raw;
    next_cf_new  = cf_new;
    if (adv)
    begin
      next_line[0] = ent_in;
      for (int i = 1; i < D; i++)
        next_line[i] = line[i-1];
      if (ent_in.fcs)
        for (int i = 1; i < pom_pkg::FCS_SPAN; i++)
          next_line[i].fcs = 1'b1;
    end
    if (in_valid_in)
    begin
      if (in_eop_in)
        next_drain = 1'b1;
      else if (in_sop_in)
        next_drain = 1'b0;
      if (in_eop_in)
        next_in_hdr = 1'b0;
      else if (ptp_start_in)
        next_in_hdr = 1'b1;
      if (ent_in.hdr && ent_in.idx != pom_pkg::IDX_MAX)
        next_idx_cnt = ent_in.idx + pom_pkg::BYTE_ONE;
      if (in_sop_in)
      begin
        next_fr_rx  = ingress_in;
        next_fr_sec = time_sec_in;
        next_fr_ns  = time_ns_in;
      end
      if (ent_in.hdr && ent_in.idx == pom_pkg::IDX_FIRST)
        next_fr_type = in_data_in[3:0];
      if (ent_in.hdr && ent_in.idx >= pom_pkg::CF_FIRST &&
          ent_in.idx <= pom_pkg::CF_LAST)
        next_cf_raw = {cf_raw[39:0], in_data_in};
      // Sum ready before byte 8 leaves
      if (ent_in.hdr && ent_in.idx == pom_pkg::CF_LAST)
        next_cf_new = next_cf_raw + adj;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < D; i++)
        line[i] <= '0;
      drain   <= 1'b0;
      in_hdr  <= 1'b0;
      idx_cnt <= pom_pkg::IDX_FIRST;
      fr_rx   <= 1'b0;
      fr_type <= pom_pkg::TYPE_SYNC;
      fr_sec  <= '0;
      fr_ns   <= '0;
      cf_raw  <= '0;
      cf_new  <= '0;
    end
    else
    begin
      line    <= next_line;
      drain   <= next_drain;
      in_hdr  <= next_in_hdr;
      idx_cnt <= next_idx_cnt;
      fr_rx   <= next_fr_rx;
      fr_type <= next_fr_type;
      fr_sec  <= next_fr_sec;
      fr_ns   <= next_fr_ns;
      cf_raw  <= next_cf_raw;
      cf_new  <= next_cf_new;
    end
  end

  // Output side: byte substitution and fcs
  always_comb
  begin
    e = line[D-1];
    sel2 = fr_rx ? rx_correction_select_in[{fr_type[2:0], 1'b0} +: 2]
                 : tx_correction_select_in[{fr_type[2:0], 1'b0} +: 2];
    // Value A is also the asymmetry term
    corr48 = fr_type[3] ? 48'h0
           : pom_pkg::pom_pick(sel2, correction_value_a_in,
                               correction_value_b_in, correction_value_c_in);
    // Add on ingress, subtract on egress
    adj = fr_rx ? corr48 : -corr48;
    // Mean path delay on ingress Sync
    if (fr_rx && fr_type == pom_pkg::TYPE_SYNC && mean_path_delay_en_in)
      adj = adj + {16'h0, mean_path_delay_in};
    if (residence_corr_en_in && (fr_type == pom_pkg::TYPE_SYNC ||
                                 fr_type == pom_pkg::TYPE_DREQ))
      adj = fr_rx ? adj - {16'h0, fr_ns} : adj + {16'h0, fr_ns};
    if (cem_mode_in)
      adj = 48'h0;
    ins_ok  = !fr_type[3] && (fr_rx ? rx_ts_write_enables_in[fr_type[2:0]]
                                    : tx_ts_write_enables_in[fr_type[2:0]]);
    // Types 8 to 15 stay untouched
    clr_ok  = !fr_type[3] && !fr_rx && egress_ts_clear_en_in;
    sec_n   = pom_pkg::pom_sec_len(seconds_insert_size_in);
    sec_rel = e.idx - seconds_insert_offset_in;
    ns_rel  = e.idx - nanos_insert_offset_in;
    sec_hit = e.hdr && sec_n != 8'h00 &&
              e.idx >= seconds_insert_offset_in && sec_rel < sec_n;
    ns_hit  = e.hdr && nanos_insert_en_in &&
              e.idx >= nanos_insert_offset_in && ns_rel < pom_pkg::NS_BYTES;
    cf_hit  = e.hdr && !cem_mode_in &&
              e.idx >= pom_pkg::CF_FIRST && e.idx <= pom_pkg::CF_LAST;
    cf_sh   = cf_new >> {pom_pkg::CF_LAST - e.idx, 3'h0};
    sec_sh  = fr_sec >> {sec_n - pom_pkg::BYTE_ONE - sec_rel, 3'h0};
    ns_sh   = fr_ns >> {pom_pkg::NS_BYTES - pom_pkg::BYTE_ONE - ns_rel, 3'h0};
    fcs_sh  = fcs_io.fcs >> {fcs_cnt, 3'h0};
    od = e.data;
    if (cf_hit)
      od = cf_sh[7:0];
    if (sec_hit && ins_ok)
      od = sec_sh[7:0];
    else if (sec_hit && clr_ok)
      od = 8'h00;
    if (ns_hit && ins_ok)
      od = ns_sh[7:0];
    else if (ns_hit && clr_ok)
      od = 8'h00;
    if (e.fcs)
      od = fcs_sh[7:0];
    fcs_io.upd     = adv & e.valid & !e.fcs;
    fcs_io.start   = e.sop;
    fcs_io.data    = od;
    next_out_valid = adv & e.valid;
    next_out_data  = od;
    next_out_sop   = adv & e.valid & e.sop;
    next_out_eop   = adv & e.valid & e.eop;
    next_fcs_cnt   = fcs_cnt;
    if (adv && e.valid)
      next_fcs_cnt = e.fcs ? fcs_cnt + 2'h1 : pom_pkg::FCS_FIRST;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      out_valid_out <= 1'b0;
      out_data_out  <= 8'h00;
      out_sop_out   <= 1'b0;
      out_eop_out   <= 1'b0;
      fcs_cnt       <= pom_pkg::FCS_FIRST;
    end
    else
    begin
      out_valid_out <= next_out_valid;
      out_data_out  <= next_out_data;
      out_sop_out   <= next_out_sop;
      out_eop_out   <= next_out_eop;
      fcs_cnt       <= next_fcs_cnt;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      pps_s1                <= 1'b0;
      pps_s2                <= 1'b0;
      pps_s3                <= 1'b0;
      event_stamp_valid_out <= 1'b0;
      event_stamp_sec_out   <= '0;
      event_stamp_ns_out    <= '0;
    end
    else
    begin
      pps_s1                <= pps_in;
      pps_s2                <= pps_s1;
      pps_s3                <= pps_s2;
      event_stamp_valid_out <= pps_s2 ^ pps_s3;
      if (pps_s2 ^ pps_s3)
      begin
        event_stamp_sec_out <= time_sec_in;
        event_stamp_ns_out  <= time_ns_in;
      end
    end
  end

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_pps_edge;
    pps_s2 != pps_s3;
  endsequence
  property p_pps_stamp;
    s_pps_edge |=> event_stamp_valid_out &&
                   event_stamp_ns_out == $past(time_ns_in);
  endproperty
  a_pps_stamp: assert property (p_pps_stamp)
    else $error("pps stamp missing or wrong");

  property p_cf_sum;
    in_valid_in && ent_in.hdr && ent_in.idx == pom_pkg::CF_LAST
      |=> cf_new == cf_raw + $past(adj);
  endproperty
  a_cf_sum: assert property (p_cf_sum)
    else $error("correction sum wrong");

  property p_mpd;
    fr_rx && fr_type == pom_pkg::TYPE_SYNC && mean_path_delay_en_in &&
    !cem_mode_in && !residence_corr_en_in
      |-> adj == corr48 + {16'h0, mean_path_delay_in};
  endproperty
  a_mpd: assert property (p_mpd)
    else $error("mean path delay not applied");

  property p_clear;
    adv && e.valid && sec_hit && !ns_hit && !ins_ok && !fr_rx &&
    !fr_type[3] && egress_ts_clear_en_in
      |=> out_valid_out && out_data_out == 8'h00;
  endproperty
  a_clear: assert property (p_clear)
    else $error("egress clear failed");

  property p_sec1;
    adv && e.valid && e.hdr && ins_ok && !ns_hit &&
    seconds_insert_size_in == pom_pkg::SEC_1B &&
    e.idx == seconds_insert_offset_in |=> out_data_out == $past(fr_sec[7:0]);
  endproperty
  a_sec1: assert property (p_sec1)
    else $error("seconds byte wrong");

  property p_ns_last;
    adv && e.valid && e.hdr && ins_ok && nanos_insert_en_in &&
    e.idx == nanos_insert_offset_in + 8'h03
      |=> out_data_out == $past(fr_ns[7:0]);
  endproperty
  a_ns_last: assert property (p_ns_last)
    else $error("nanoseconds byte wrong");

  property p_pass;
    adv && e.valid && !e.hdr && !e.fcs |=> out_data_out == $past(e.data);
  endproperty
  a_pass: assert property (p_pass)
    else $error("non header byte altered");

  property p_cem_cf;
    adv && e.valid && cem_mode_in && e.hdr && !e.fcs && !sec_hit && !ns_hit
      |=> out_data_out == $past(e.data);
  endproperty
  a_cem_cf: assert property (p_cem_cf)
    else $error("ce packet header altered");

  property p_fcs_end;
    out_valid_out && out_eop_out |-> out_data_out == fcs_io.fcs[31:24];
  endproperty
  a_fcs_end: assert property (p_fcs_end)
    else $error("fcs last byte wrong");
endmodule
`default_nettype wire

// ==== test/pom_sink.sv ====
`timescale 1ns/1ps
`default_nettype none
module pom_sink (
  input wire logic       mclk_in,
  input wire logic       rst_n_in,
  input wire logic       valid_in,
  input wire logic [7:0] data_in,
  input wire logic       sop_in,
  input wire logic       eop_in
);
  logic [7:0] frame [$];
  int         frames = 0;

  // Receiving MAC; no back-pressure, so every byte is taken
  always @(posedge mclk_in)
  begin
    if (rst_n_in && valid_in)
    begin
      if (sop_in)
        frame.delete();
      frame.push_back(data_in);
      if (eop_in)
        frames++;
    end
  end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        mclk_in  = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        vld      = 1'b0;
  logic        sop      = 1'b0;
  logic        eop      = 1'b0;
  logic        pstart   = 1'b0;
  logic        ing      = 1'b0;
  logic        pps      = 1'b0;
  logic        clr      = 1'b1;
  logic        ns_en    = 1'b1;
  logic        mpd_en   = 1'b1;
  logic        res      = 1'b0;
  logic        cem      = 1'b0;
  logic [7:0]  din      = 8'h00;
  logic [47:0] tsec     = 48'h0123456789ab;
  logic [31:0] tns      = 32'h1234abcd;
  logic [1:0]  ssize    = 2'h3;
  logic [7:0]  soff     = 8'h22;
  logic [7:0]  noff     = 8'h28;
  logic [7:0]  rx_en    = 8'h01;
  logic [7:0]  tx_en    = 8'h01;
  logic [31:0] ca       = 32'hfffffc18;
  logic [31:0] cb       = 32'h00000200;
  logic [31:0] cc       = 32'h00000011;
  logic [31:0] mpd      = 32'h00000064;
  logic [15:0] rx_sel   = 16'h0001;
  logic [15:0] tx_sel   = 16'h000b;
  logic        ov;
  logic        os;
  logic        oe;
  logic        ev;
  logic [7:0]  od;
  logic [47:0] esec;
  logic [31:0] ens;
  logic [7:0]  src  [64];
  logic [7:0]  want [64];
  int          errors = 0;
  int          checks = 0;
  int          cycles = 0;

  pom_top u_pom_top (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .in_valid_in(vld),
    .in_data_in(din), .in_sop_in(sop), .in_eop_in(eop),
    .ptp_start_in(pstart), .ingress_in(ing), .time_sec_in(tsec),
    .time_ns_in(tns), .pps_in(pps), .egress_ts_clear_en_in(clr),
    .seconds_insert_size_in(ssize), .seconds_insert_offset_in(soff),
    .nanos_insert_en_in(ns_en), .nanos_insert_offset_in(noff),
    .rx_ts_write_enables_in(rx_en), .tx_ts_write_enables_in(tx_en),
    .correction_value_a_in(ca), .correction_value_b_in(cb),
    .correction_value_c_in(cc), .rx_correction_select_in(rx_sel),
    .tx_correction_select_in(tx_sel), .mean_path_delay_in(mpd),
    .mean_path_delay_en_in(mpd_en), .residence_corr_en_in(res),
    .cem_mode_in(cem), .out_valid_out(ov), .out_data_out(od),
    .out_sop_out(os), .out_eop_out(oe), .event_stamp_valid_out(ev),
    .event_stamp_sec_out(esec), .event_stamp_ns_out(ens)
  );

  pom_sink u_sink (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .valid_in(ov),
    .data_in(od), .sop_in(os), .eop_in(oe)
  );

  always #5 mclk_in = ~mclk_in;

  // Guard against a hung stream; runs take about 1150 cycles
  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      complete_run();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Own bytewise reflected CRC, not shared with the design
  function automatic logic [31:0] crc_of(input logic [7:0] a [64]);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < 60; i++)
    begin
      c = c ^ {24'h000000, a[i]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
    end
    return ~c;
  endfunction

  task automatic run_frame(input logic [3:0] t, input logic dir);
    logic [47:0] cf;
    logic [47:0] adj;
    logic [1:0]  sel;
    logic        ins;
    int          n;
    int          f0;
    // Config set by the caller lands first
    @(posedge mclk_in);
    for (int i = 0; i < 64; i++)
      src[i] = 8'(i * 7 + 3);
    src[14] = {4'h0, t};
    {src[22], src[23], src[24], src[25], src[26], src[27]} = 48'h10000;
    {src[63], src[62], src[61], src[60]} = crc_of(src);
    want = src;
    if (t < 4'h8)
    begin
      ins = dir ? rx_en[t] : tx_en[t];
      sel = dir ? rx_sel[2*t +: 2] : tx_sel[2*t +: 2];
      adj = (sel == 2'h1) ? {{16{ca[31]}}, ca} :
            (sel == 2'h2) ? {{16{cb[31]}}, cb} :
            (sel == 2'h3) ? {{16{cc[31]}}, cc} : 48'h0;
      if (!dir)
        adj = -adj;
      if (dir && t == 4'h0 && mpd_en)
        adj = adj + {16'h0000, mpd};
      if (res && t < 4'h2)
        adj = dir ? adj - {16'h0000, tns} : adj + {16'h0000, tns};
      if (cem)
        adj = 48'h0;
      cf = {want[22], want[23], want[24], want[25], want[26], want[27]};
      {want[22], want[23], want[24], want[25], want[26], want[27]} = cf + adj;
      n = (ssize == 2'h1) ? 1 : (ssize == 2'h2) ? 4 : (ssize == 2'h3) ? 6 : 0;
      for (int k = 0; k < n; k++)
        if (ins || (!dir && clr))
          want[14 + soff + k] = ins ? tsec[8*(n-1-k) +: 8] : 8'h00;
      for (int k = 0; k < 4; k++)
        if (ns_en && (ins || (!dir && clr)))
          want[14 + noff + k] = ins ? tns[8*(3-k) +: 8] : 8'h00;
    end
    {want[63], want[62], want[61], want[60]} = crc_of(want);
    f0 = u_sink.frames;
    for (int i = 0; i < 64; i++)
    begin
      @(posedge mclk_in);
      vld    <= 1'b1;
      din    <= src[i];
      sop    <= (i == 0);
      eop    <= (i == 63);
      pstart <= (i == 14);
      ing    <= dir;
    end
    @(posedge mclk_in);
    vld <= 1'b0;
    sop <= 1'b0;
    eop <= 1'b0;
    pstart <= 1'b0;
    for (int w = 0; w < 40 && u_sink.frames == f0; w++)
      @(posedge mclk_in);
    check(u_sink.frames, f0 + 1);
    check(u_sink.frame.size(), 64);
    for (int i = 0; i < 64; i++)
      check(u_sink.frame[i], want[i]);
    $display("frame type %0d dir %0d done", t, dir);
  endtask

  task automatic pps_edges();
    for (int e = 0; e < 2; e++)
    begin
      @(posedge mclk_in);
      tsec <= tsec + 48'h1;
      tns  <= 32'h00000007 + e;
      pps  <= ~pps;
      for (int w = 0; w < 8 && ev !== 1'b1; w++)
        @(posedge mclk_in);
      check(ev, 1'b1);
      check(ens, tns);
      check(esec, tsec);
      @(posedge mclk_in);
    end
    $display("pps stamping done");
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Each seconds size on ingress Sync, offsets from header start
  task automatic seconds_sizes();
    for (int s = 0; s < 4; s++)
    begin
      @(posedge mclk_in);
      ssize <= 2'(s);
      run_frame(4'h0, 1'b1);
    end
  endtask

  // Egress Sync inserts; egress type 1 is cleared instead
  task automatic egress_frames();
    run_frame(4'h0, 1'b0);
    run_frame(4'h1, 1'b0);
  endtask

  // Disabled type 2 on ingress and types 8, 9 pass unaltered, type 9 on egress
  task automatic disabled_types();
    run_frame(4'h2, 1'b1);
    run_frame(4'h8, 1'b1);
    run_frame(4'h9, 1'b0);
  endtask

  // Only the last ingress type enabled, value C, no path delay
  task automatic last_type_frame();
    @(posedge mclk_in);
    rx_en  <= 8'h80;
    rx_sel <= 16'hc000;
    mpd_en <= 1'b0;
    run_frame(4'h7, 1'b1);
  endtask

  // Residence term only on types 0 and 1, sign by direction
  task automatic residence_frames();
    @(posedge mclk_in);
    res <= 1'b1;
    run_frame(4'h1, 1'b1);
    run_frame(4'h0, 1'b0);
    run_frame(4'h2, 1'b0);
  endtask

  // CE mode keeps correctionField, stamps still written
  task automatic ce_frames();
    @(posedge mclk_in);
    res <= 1'b0;
    cem <= 1'b1;
    run_frame(4'h7, 1'b1);
    run_frame(4'h0, 1'b0);
  endtask

  initial
  begin
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    seconds_sizes();
    egress_frames();
    disabled_types();
    last_type_frame();
    residence_frames();
    ce_frames();
    pps_edges();
    complete_run();
  end
endmodule
`default_nettype wire
